// file: shared/hsld_pkg.sv
// Package of constants and types for the hub strap latch and decode block
package hsld_pkg;

    // Number of downstream ports with disable straps
    localparam int unsigned HSLD_NUM_PORTS = 6;

    // Width of the decoded mode strap code
    localparam int unsigned HSLD_MODE_W = 3;

    // Mode strap codes as delivered by the strap level sensor
    typedef enum logic [2:0] {
        HSLD_BRIDGE_MASTER_SETTING = 3'h0,
        HSLD_MGMT_SLAVE_SETTING    = 3'h1,
        HSLD_RESERVED_SETTING_A    = 3'h2,
        HSLD_RESERVED_SETTING_B    = 3'h3,
        HSLD_RESERVED_SETTING_C    = 3'h4,
        HSLD_RESERVED_SETTING_D    = 3'h5
    } hsld_mode_t;

    // Values after reset
    localparam logic [2:0] HSLD_MODE_RST    = 3'h0;
    localparam logic [5:0] HSLD_STRAP_RST   = 6'h00;

    // Capture sequencer states
    typedef enum logic [1:0] {
        HSLD_ST_SYNC    = 2'b00,
        HSLD_ST_CAPTURE = 2'b01,
        HSLD_ST_HOLD    = 2'b10
    } hsld_state_t;

    // Cycles spent filling the strap synchronisers after reset release
    localparam logic [1:0] HSLD_SYNC_CYCLES = 2'h2;

endpackage : hsld_pkg

// file: hw/hsld_strap_latch.sv
// Strap capture at reset release and decode of mode and port disables
`timescale 1ns/100ps

// Behaviour
// - Capture all straps when reset ends
// - First mode code selects bridging master
// - Second mode code selects management slave
// - Codes three to six reserved, no function
// - Positive-line strap one disables positive line
// - Negative-line strap one disables negative line
// - Port disabled only when both straps high
// - Port disable also kills SuperSpeed function
// - Capture again on chip reset rising
// - No capture while chip reset low
module hsld_strap_latch
    import hsld_pkg::*;
#(
    parameter int unsigned NUM_PORTS = HSLD_NUM_PORTS
) (
    input  wire logic                 clock_i,
    input  wire logic                 reset_n_i,
    input  wire logic [2:0]           mode_strap_i,
    input  wire logic [NUM_PORTS-1:0] port_pos_line_disable_strap_i,
    input  wire logic [NUM_PORTS-1:0] port_neg_line_disable_strap_i,
    output logic                      strap_valid_o,
    output logic                      bridge_master_en_o,
    output logic                      mgmt_slave_en_o,
    output logic                      mode_reserved_o,
    output logic [2:0]                mode_code_o,
    output logic [NUM_PORTS-1:0]      pos_line_disabled_o,
    output logic [NUM_PORTS-1:0]      neg_line_disabled_o,
    output logic [NUM_PORTS-1:0]      hs_port_disabled_o,
    output logic [NUM_PORTS-1:0]      ss_port_disabled_o
);

    // Synchroniser stages for the strap pins
    logic [2:0]           mode_s1_q;
    logic [2:0]           mode_s2_q;
    logic [NUM_PORTS-1:0] pos_s1_q;
    logic [NUM_PORTS-1:0] pos_s2_q;
    logic [NUM_PORTS-1:0] neg_s1_q;
    logic [NUM_PORTS-1:0] neg_s2_q;

    // Synchroniser next values
    logic [2:0]           mode_s1_d;
    logic [2:0]           mode_s2_d;
    logic [NUM_PORTS-1:0] pos_s1_d;
    logic [NUM_PORTS-1:0] pos_s2_d;
    logic [NUM_PORTS-1:0] neg_s1_d;
    logic [NUM_PORTS-1:0] neg_s2_d;

    // Sequencer state
    hsld_state_t          state_q;
    hsld_state_t          state_d;
    logic [1:0]           cnt_q;
    logic [1:0]           cnt_d;

    // Capture strobe from the sequencer to the strap latch
    logic                 cap_en;

    // Latched straps
    logic [2:0]           mode_lat_q;
    logic [2:0]           mode_lat_d;
    logic [NUM_PORTS-1:0] pos_lat_q;
    logic [NUM_PORTS-1:0] pos_lat_d;
    logic [NUM_PORTS-1:0] neg_lat_q;
    logic [NUM_PORTS-1:0] neg_lat_d;
    logic                 valid_q;
    logic                 valid_d;

    // Decoded outputs
    logic                 bridge_q;
    logic                 bridge_d;
    logic                 slave_q;
    logic                 slave_d;
    logic                 rsvd_q;
    logic                 rsvd_d;
    logic [NUM_PORTS-1:0] hs_dis_q;
    logic [NUM_PORTS-1:0] hs_dis_d;

    // Synchroniser next values: first stage from pins, second from first only
    always_comb begin
        mode_s1_d = mode_strap_i;
        mode_s2_d = mode_s1_q;
        pos_s1_d  = port_pos_line_disable_strap_i;
        pos_s2_d  = pos_s1_q;
        neg_s1_d  = port_neg_line_disable_strap_i;
        neg_s2_d  = neg_s1_q;
    end

    // Two-flop synchronisers; reset holds them cleared while chip reset is low
    // Cleared in reset so no stale pin value from before reset can be latched
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_s1_q <= HSLD_MODE_RST;
            mode_s2_q <= HSLD_MODE_RST;
            pos_s1_q  <= '0;
            pos_s2_q  <= '0;
            neg_s1_q  <= '0;
            neg_s2_q  <= '0;
        end else begin
            mode_s1_q <= mode_s1_d;
            mode_s2_q <= mode_s2_d;
            pos_s1_q  <= pos_s1_d;
            pos_s2_q  <= pos_s2_d;
            neg_s1_q  <= neg_s1_d;
            neg_s2_q  <= neg_s2_d;
        end
    end

    // Sequencer: fill synchronisers, capture once, then hold
    // Waiting two cycles lets post-reset pin levels reach the second stage
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cap_en  = 1'b0;
        case (state_q)
            HSLD_ST_SYNC: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == HSLD_SYNC_CYCLES - 2'h1) begin
                    state_d = HSLD_ST_CAPTURE;
                end
            end
            HSLD_ST_CAPTURE: begin
                cap_en  = 1'b1;
                state_d = HSLD_ST_HOLD;
            end
            HSLD_ST_HOLD: begin
                state_d = HSLD_ST_HOLD;
            end
            default: begin
                state_d = HSLD_ST_SYNC;
            end
        endcase
    end

    // Sequencer registers; every reset release restarts capture
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= HSLD_ST_SYNC;
            cnt_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Strap latch: load synchronised straps on the capture cycle only
    // Any strap movement after capture is ignored until the next reset
    always_comb begin
        mode_lat_d = mode_lat_q;
        pos_lat_d  = pos_lat_q;
        neg_lat_d  = neg_lat_q;
        valid_d    = valid_q;
        if (cap_en) begin
            mode_lat_d = mode_s2_q;
            pos_lat_d  = pos_s2_q;
            neg_lat_d  = neg_s2_q;
            valid_d    = 1'b1;
        end
    end

    // Latch registers; cleared and held while chip reset is low
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_lat_q <= HSLD_MODE_RST;
            pos_lat_q  <= HSLD_STRAP_RST[NUM_PORTS-1:0];
            neg_lat_q  <= HSLD_STRAP_RST[NUM_PORTS-1:0];
            valid_q    <= 1'b0;
        end else begin
            mode_lat_q <= mode_lat_d;
            pos_lat_q  <= pos_lat_d;
            neg_lat_q  <= neg_lat_d;
            valid_q    <= valid_d;
        end
    end

    // Mode decode from the captured value
    // Works on next values so the flags rise together with strap_valid_o
    always_comb begin
        bridge_d = 1'b0;
        slave_d  = 1'b0;
        rsvd_d   = 1'b0;
        if (valid_d) begin
            case (mode_lat_d)
                HSLD_BRIDGE_MASTER_SETTING: bridge_d = 1'b1;
                HSLD_MGMT_SLAVE_SETTING:    slave_d  = 1'b1;
                default:                    rsvd_d   = 1'b1;
            endcase
        end
    end

    // Port disable needs both line straps high
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign hs_dis_d[p] = valid_d & pos_lat_d[p] & neg_lat_d[p];
    end

    // Registered decode outputs
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bridge_q <= 1'b0;
            slave_q  <= 1'b0;
            rsvd_q   <= 1'b0;
            hs_dis_q <= '0;
        end else begin
            bridge_q <= bridge_d;
            slave_q  <= slave_d;
            rsvd_q   <= rsvd_d;
            hs_dis_q <= hs_dis_d;
        end
    end

    // Outputs straight from flip-flops
    // SuperSpeed disable shares the USB 2.0 disable flop
    assign strap_valid_o       = valid_q;
    assign mode_code_o         = mode_lat_q;
    assign bridge_master_en_o  = bridge_q;
    assign mgmt_slave_en_o     = slave_q;
    assign mode_reserved_o     = rsvd_q;
    assign pos_line_disabled_o = pos_lat_q;
    assign neg_line_disabled_o = neg_lat_q;
    assign hs_port_disabled_o  = hs_dis_q;
    assign ss_port_disabled_o  = hs_dis_q;

endmodule : hsld_strap_latch

// file: dv/hsld_board.sv
// Board strap resistors feeding the block
`timescale 1ns/100ps
module hsld_board (
    input  wire logic [2:0] mode_sel_i,
    input  wire logic [5:0] pos_sel_i,
    input  wire logic [5:0] neg_sel_i,
    output logic      [2:0] mode_strap_o,
    output logic      [5:0] pos_strap_o,
    output logic      [5:0] neg_strap_o
);
    // Straps held at the chosen level through the latch point
    assign mode_strap_o = mode_sel_i;
    assign pos_strap_o  = pos_sel_i;
    assign neg_strap_o  = neg_sel_i;
endmodule : hsld_board

// file: dv/hsld_strap_latch_assertions.sv
// Checker for strap capture and decode
`timescale 1ns/100ps
module hsld_chk #(
    parameter int unsigned NUM_PORTS = 6
) (
    input wire logic                 clock_i,
    input wire logic                 reset_n_i,
    input wire logic [2:0]           mode_strap_i,
    input wire logic [NUM_PORTS-1:0] port_pos_line_disable_strap_i,
    input wire logic [NUM_PORTS-1:0] port_neg_line_disable_strap_i,
    input wire logic                 strap_valid_o,
    input wire logic                 bridge_master_en_o,
    input wire logic                 mgmt_slave_en_o,
    input wire logic                 mode_reserved_o,
    input wire logic [2:0]           mode_code_o,
    input wire logic [NUM_PORTS-1:0] pos_line_disabled_o,
    input wire logic [NUM_PORTS-1:0] neg_line_disabled_o,
    input wire logic [NUM_PORTS-1:0] hs_port_disabled_o,
    input wire logic [NUM_PORTS-1:0] ss_port_disabled_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       quiet;
    // Edges since reset release, saturating at three
    always_comb cnt_d = cnt_q + {1'b0, cnt_q != 2'h3};
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // All latched outputs still at their reset level
    assign quiet = !(|{mode_code_o, pos_line_disabled_o, neg_line_disabled_o, bridge_master_en_o,
        mgmt_slave_en_o, mode_reserved_o, hs_port_disabled_o, ss_port_disabled_o});
    sequence s_cap;
        $rose(strap_valid_o);
    endsequence
    sequence s_latched;
        mode_code_o == $past(mode_strap_i, 3) && pos_line_disabled_o == $past(port_pos_line_disable_strap_i, 3)
            && neg_line_disabled_o == $past(port_neg_line_disable_strap_i, 3);
    endsequence
    property p_hold;
        strap_valid_o |=> strap_valid_o && $stable({mode_code_o, pos_line_disabled_o, neg_line_disabled_o});
    endproperty
    a_valid_third: assert property (strap_valid_o == (cnt_q == 2'h3)) else $error("bad valid timing");
    a_quiet_before: assert property (!strap_valid_o |-> quiet) else $error("output before capture");
    a_bridge_decode: assert property (bridge_master_en_o == (strap_valid_o && mode_code_o == 3'h0))
        else $error("bridge decode");
    a_slave_decode: assert property (mgmt_slave_en_o == (strap_valid_o && mode_code_o == 3'h1))
        else $error("slave decode");
    a_reserved_decode: assert property (mode_reserved_o == (strap_valid_o && mode_code_o > 3'h1))
        else $error("reserved decode");
    a_both_high: assert property (hs_port_disabled_o == (pos_line_disabled_o & neg_line_disabled_o))
        else $error("port disable");
    a_ss_follow: assert property (ss_port_disabled_o == hs_port_disabled_o) else $error("ss disable");
    a_hold_stable: assert property (p_hold) else $error("latch moved");
    a_capture_value: assert property (s_cap |-> s_latched) else $error("wrong capture");
endmodule : hsld_chk
bind hsld_strap_latch hsld_chk #(
    .NUM_PORTS(NUM_PORTS)
) chk_u (
    .clock_i                       (clock_i),
    .reset_n_i                     (reset_n_i),
    .mode_strap_i                  (mode_strap_i),
    .port_pos_line_disable_strap_i (port_pos_line_disable_strap_i),
    .port_neg_line_disable_strap_i (port_neg_line_disable_strap_i),
    .strap_valid_o                 (strap_valid_o),
    .bridge_master_en_o            (bridge_master_en_o),
    .mgmt_slave_en_o               (mgmt_slave_en_o),
    .mode_reserved_o               (mode_reserved_o),
    .mode_code_o                   (mode_code_o),
    .pos_line_disabled_o           (pos_line_disabled_o),
    .neg_line_disabled_o           (neg_line_disabled_o),
    .hs_port_disabled_o            (hs_port_disabled_o),
    .ss_port_disabled_o            (ss_port_disabled_o)
);

// file: dv/hub_strap_latch_decode_tb.sv
// Testbench for strap latch and decode
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, e); end end
module hub_strap_latch_decode_tb;
    logic       clock_i   = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [2:0] mode_sel  = 3'h0;
    logic [5:0] pos_sel   = 6'h00;
    logic [5:0] neg_sel   = 6'h00;
    logic [2:0] mode_strap, mode_code;
    logic [5:0] pos_strap, neg_strap, pos_dis, neg_dis, hs_dis, ss_dis;
    logic       valid, bridge, slave, rsvd;
    int         n_fail = 0;
    int         checks = 0;
    // Clock at 4 ns
    initial forever #2 clock_i = ~clock_i;
    hsld_board board_u (.mode_sel_i(mode_sel), .pos_sel_i(pos_sel), .neg_sel_i(neg_sel),
        .mode_strap_o(mode_strap), .pos_strap_o(pos_strap), .neg_strap_o(neg_strap));
    hsld_strap_latch #(.NUM_PORTS(6)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .mode_strap_i(mode_strap), .port_pos_line_disable_strap_i(pos_strap),
        .port_neg_line_disable_strap_i(neg_strap), .strap_valid_o(valid), .bridge_master_en_o(bridge),
        .mgmt_slave_en_o(slave), .mode_reserved_o(rsvd), .mode_code_o(mode_code), .pos_line_disabled_o(pos_dis),
        .neg_line_disabled_o(neg_dis), .hs_port_disabled_o(hs_dis), .ss_port_disabled_o(ss_dis));
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // Reset for two cycles, then count edges until capture
    task automatic pulse_reset(output int n);
        @(posedge clock_i) reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        `CHK({valid, mode_code, pos_dis, hs_dis}, 16'h0000)
        reset_n_i <= 1'b1;
        n = 0;
        while (valid !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 8) begin n_fail++; finish_test(); end
        end
    endtask : pulse_reset
    // Capture one strap set, then move straps and confirm the latch holds
    task automatic run_case(input logic [2:0] m, input logic [5:0] p, input logic [5:0] q);
        int n;
        @(posedge clock_i);
        mode_sel <= m;
        pos_sel  <= p;
        neg_sel  <= q;
        pulse_reset(n);
        `CHK(n, 3)
        `CHK(mode_code, m)
        `CHK({bridge, slave, rsvd}, {m == 3'h0, m == 3'h1, m > 3'h1})
        `CHK({pos_dis, neg_dis}, {p, q})
        `CHK({hs_dis, ss_dis}, {p & q, p & q})
        @(posedge clock_i);
        mode_sel <= ~m;
        pos_sel  <= ~p;
        neg_sel  <= ~q;
        repeat (4) @(posedge clock_i);
        #1;
        `CHK({valid, mode_code, pos_dis, neg_dis, hs_dis}, {1'b1, m, p, q, p & q})
    endtask : run_case
    // Reset cut short before the capture edge
    task automatic run_abort();
        @(posedge clock_i) reset_n_i <= 1'b0;
        @(posedge clock_i) reset_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        `CHK({valid, pos_dis}, 7'h00)
    endtask : run_abort
    // Main sequence
    initial begin
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            run_case(3'(i), 6'h35 ^ 6'(i), 6'h1c ^ 6'(i << 3));
        end
        run_abort();
        run_case(3'h1, 6'h3f, 6'h3f);
        run_case(3'h0, 6'h00, 6'h00);
        finish_test();
    end
endmodule : hub_strap_latch_decode_tb
